// ### core/pmdc_ctrl.sv
// pmdc_ctrl: page-mode dram controller for a dsp primary bus, four banks of 256K x 32
// assumes ref_clk is the delayed copy of the processor output clock and that the
// processor waits on bus_ready and keeps strobe low between same-page reads
//
// Operation
// - four banks of 256K x 32 words
// - refresh by cas-before-ras, no row counter
// - one refresh per host dma request
// - read 3/5 clocks, write 3/4 clocks
// - page reads 3 first, then 2 each
// - access counted from strobe to data capture
// - non-page cycle includes ras precharge
// - bank address ranges, own ras/cas pair
// - module select on board range 4xxxxxH
// - bank chosen by address bits 18, 19
// - all state clocked from delayed cpu clock
// - hold ras low, toggle cas on reads
// - strobe high in page mode forces ras and cas high
// - row address first, column after delay
`timescale 1ns/1ps
`include "pmdc_map.svh"

module pmdc_ctrl (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic bus_strobe_n,
   input wire logic bus_rw,
   input wire logic [23:0] bus_addr,
   input wire logic host_dma_ack_refresh_req,
   output logic bus_ready,
   output logic module_select,
   output logic row_column_select,
   output logic [8:0] dram_mux_address,
   output logic data_latch_en,
   output pmdc_pkg::pmdc_dram_ctl_s dram_ctl
);

   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   function automatic logic board_hit(input logic [23:0] a);
      board_hit = (a[`PMDC_BOARD_HI:`PMDC_BOARD_LO] == `PMDC_BOARD_BASE);
   endfunction : board_hit

   function automatic logic [3:0] bank_onehot(input logic [23:0] a);
      bank_onehot = 4'h1 << a[`PMDC_BANK_HI:`PMDC_BANK_LO];
   endfunction : bank_onehot

   pmdc_pkg::pmdc_state_e state_reg;
   logic [2:0] count_reg;
   logic [3:0] bank_reg;
   logic [8:0] row_reg;
   logic [8:0] col_reg;
   logic write_reg;
   logic ready_reg;
   logic latch_reg;
   logic rcs_reg;
   logic [3:0] ras_n_reg;
   logic [3:0] cas_n_reg;
   logic we_n_reg;
   logic [2:0] req_sync_reg;
   logic refresh_pend_reg;
   logic [23:0] last_addr_reg;
   logic sel;
   logic req_rise;
   logic new_page_read;

   // ---------------------------------------------------------------
   // refresh request capture
   // ---------------------------------------------------------------
   // host request comes from another clock domain: three flops, count when the 2nd is high and the 3rd still low
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         req_sync_reg <= 3'h0;
      end else begin
         req_sync_reg <= {req_sync_reg[1:0], host_dma_ack_refresh_req};
      end
   end

   assign req_rise = req_sync_reg[1] & ~req_sync_reg[2];

   // pending flag: new request wins over the clear on the last clock of refresh
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         refresh_pend_reg <= 1'b0;
      end else if (req_rise) begin
         refresh_pend_reg <= 1'b1;
      end else if (state_reg == pmdc_pkg::ST_REFRESH && count_reg == 3'h0) begin
         refresh_pend_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // access detection
   // ---------------------------------------------------------------
   assign sel = ~bus_strobe_n & board_hit(bus_addr);
   assign module_select = board_hit(bus_addr);
   // page hit: read, same bank and same row as the open page, address moved on
   assign new_page_read = sel & bus_rw & (bus_addr != last_addr_reg)
      & (bank_onehot(bus_addr) == bank_reg)
      & (bus_addr[`PMDC_ROW_HI:`PMDC_ROW_LO] == row_reg);

   // ---------------------------------------------------------------
   // main timing machine
   // ---------------------------------------------------------------
   // count_reg times each phase; all in the delayed cpu clock domain
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_reg <= pmdc_pkg::ST_IDLE;
         count_reg <= 3'h0;
         bank_reg <= 4'h0;
         row_reg <= 9'h000;
         col_reg <= 9'h000;
         write_reg <= 1'b0;
         last_addr_reg <= 24'h000000;
      end else begin
         case (state_reg)
            pmdc_pkg::ST_IDLE: begin
               if (refresh_pend_reg) begin
                  state_reg <= pmdc_pkg::ST_REFRESH;
                  count_reg <= `PMDC_RD_CYCLE;
               end else if (sel) begin
                  state_reg <= pmdc_pkg::ST_ACCESS;
                  count_reg <= 3'h1; // strobe cycle is clock 1
                  bank_reg <= bank_onehot(bus_addr);
                  row_reg <= bus_addr[`PMDC_ROW_HI:`PMDC_ROW_LO];
                  col_reg <= bus_addr[`PMDC_COL_HI:`PMDC_COL_LO];
                  write_reg <= ~bus_rw;
                  last_addr_reg <= bus_addr;
               end
            end
            pmdc_pkg::ST_ACCESS: begin
               count_reg <= count_reg + 3'h1;
               // read and write both deliver at clock 3
               if (count_reg == `PMDC_RD_ACCESS - 3'h1) begin
                  state_reg <= write_reg ? pmdc_pkg::ST_PRECHARGE : pmdc_pkg::ST_PAGE;
                  count_reg <= write_reg ? (`PMDC_WR_CYCLE - `PMDC_WR_ACCESS)
                     : (`PMDC_RD_CYCLE - `PMDC_RD_ACCESS);
               end
            end
            pmdc_pkg::ST_PAGE: begin
               // row stays open while strobe is held low
               if (bus_strobe_n) begin
                  state_reg <= pmdc_pkg::ST_PRECHARGE;
                  // a page burst leaves the counter spent: reload the full precharge
                  count_reg <= `PMDC_RD_CYCLE - `PMDC_RD_ACCESS;
               end else if (new_page_read) begin
                  state_reg <= pmdc_pkg::ST_PAGE_WAIT;
                  col_reg <= bus_addr[`PMDC_COL_HI:`PMDC_COL_LO];
                  last_addr_reg <= bus_addr;
                  count_reg <= `PMDC_PG_ACCESS - 3'h1;
               end
            end
            pmdc_pkg::ST_PAGE_WAIT: begin
               count_reg <= count_reg - 3'h1;
               if (count_reg == 3'h1) begin
                  state_reg <= pmdc_pkg::ST_PAGE;
               end
            end
            pmdc_pkg::ST_PRECHARGE: begin
               // ras precharge before the next non-page access
               if (count_reg > 3'h1) begin
                  count_reg <= count_reg - 3'h1;
               end else begin
                  count_reg <= 3'h0;
                  state_reg <= pmdc_pkg::ST_IDLE;
               end
            end
            pmdc_pkg::ST_REFRESH: begin
               // cas-before-ras: dram supplies row address itself
               if (count_reg != 3'h0) begin
                  count_reg <= count_reg - 3'h1;
               end else begin
                  state_reg <= pmdc_pkg::ST_IDLE;
               end
            end
            default: state_reg <= pmdc_pkg::ST_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // dram strobes and address mux
   // ---------------------------------------------------------------
   // ras on the selected bank during access/page, cas on the same clock as the mux swap
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ras_n_reg <= 4'hF;
         cas_n_reg <= 4'hF;
         we_n_reg <= 1'b1;
         rcs_reg <= 1'b0;
      end else begin
         case (state_reg)
            pmdc_pkg::ST_ACCESS: begin
               ras_n_reg <= ~bank_reg;
               // row stays on the mux for one clock after ras falls, then column
               rcs_reg <= (count_reg >= `PMDC_MUX_DELAY + 3'h1);
               cas_n_reg <= (count_reg >= `PMDC_MUX_DELAY + 3'h1) ? ~bank_reg : 4'hF;
               we_n_reg <= ~write_reg;
            end
            pmdc_pkg::ST_PAGE: begin
               ras_n_reg <= bus_strobe_n ? 4'hF : ~bank_reg;
               cas_n_reg <= (bus_strobe_n | new_page_read) ? 4'hF : cas_n_reg;
               we_n_reg <= 1'b1;
            end
            pmdc_pkg::ST_PAGE_WAIT: begin
               cas_n_reg <= ~bank_reg; // cas falls again on the new column
            end
            pmdc_pkg::ST_REFRESH: begin
               // all banks: cas first, ras one clock later
               cas_n_reg <= (count_reg > 3'h1) ? 4'h0 : 4'hF;
               ras_n_reg <= (count_reg > 3'h1 && count_reg < `PMDC_RD_CYCLE) ? 4'h0 : 4'hF;
               we_n_reg <= 1'b1;
               rcs_reg <= 1'b0;
            end
            default: begin
               ras_n_reg <= 4'hF;
               cas_n_reg <= 4'hF;
               we_n_reg <= 1'b1;
               rcs_reg <= 1'b0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // processor handshake
   // ---------------------------------------------------------------
   // ready is a registered pulse one clock before capture, so data lands at clock 3
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ready_reg <= 1'b0;
         latch_reg <= 1'b0;
      end else begin
         ready_reg <= ((state_reg == pmdc_pkg::ST_ACCESS) && (count_reg == `PMDC_RD_ACCESS - 3'h1))
            || ((state_reg == pmdc_pkg::ST_PAGE_WAIT) && (count_reg == 3'h1));
         latch_reg <= ~write_reg && (state_reg == pmdc_pkg::ST_ACCESS || state_reg == pmdc_pkg::ST_PAGE_WAIT);
      end
   end

   // a pending refresh holds the cpu off by not taking its next strobe
   // gating ready here would deadlock an access already under way
   assign bus_ready = ready_reg;
   assign data_latch_en = latch_reg;
   assign row_column_select = rcs_reg;
   // 9-bit multiplexed address: row then column of the 512 x 512 array
   assign dram_mux_address = rcs_reg ? col_reg : row_reg;
   assign dram_ctl.ras_n = ras_n_reg;
   assign dram_ctl.cas_n = cas_n_reg;
   assign dram_ctl.we_n = we_n_reg;

endmodule : pmdc_ctrl

// ### core/pmdc_map.svh
// pmdc_map.svh: address map and cycle counts for the page-mode dram controller
// assumes a 24-bit processor word address and a 100 MHz ref_clk
`ifndef PMDC_MAP_SVH
`define PMDC_MAP_SVH
`define PMDC_BOARD_BASE 4'h4
`define PMDC_BOARD_HI 23
`define PMDC_BOARD_LO 20
`define PMDC_BANK_HI 19
`define PMDC_BANK_LO 18
`define PMDC_ROW_HI 17
`define PMDC_ROW_LO 9
`define PMDC_COL_HI 8
`define PMDC_COL_LO 0
`define PMDC_RD_ACCESS 3'h3
`define PMDC_RD_CYCLE 3'h5
`define PMDC_WR_ACCESS 3'h3
`define PMDC_WR_CYCLE 3'h4
`define PMDC_PG_ACCESS 3'h2
`define PMDC_MUX_DELAY 3'h1
`endif

// ### core/pmdc_pkg.sv
// pmdc_pkg: types shared by the page-mode dram controller
// assumes pmdc_map.svh supplies the numeric constants
package pmdc_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ACCESS,
      ST_PAGE,
      ST_PAGE_WAIT,
      ST_PRECHARGE,
      ST_REFRESH
   } pmdc_state_e;

   // dram-side control strobes, all active low
   typedef struct packed {
      logic [3:0] ras_n;
      logic [3:0] cas_n;
      logic we_n;
   } pmdc_dram_ctl_s;
endpackage : pmdc_pkg

// ### test/pmdc_cpu_model.sv
// pmdc_cpu_model: processor bus master driving the controller
// assumes the shared ref_clk; signals change only at rising edges
`timescale 1ns/1ps
module pmdc_cpu_model (
   input wire logic ref_clk,
   input wire logic bus_ready,
   output logic bus_strobe_n,
   output logic bus_rw,
   output logic [23:0] bus_addr
);
   int cyc = 0;
   initial begin
      bus_strobe_n = 1'b1;
      bus_rw = 1'b1;
      bus_addr = 24'h000000;
   end
   // cycle stamp, used to measure ready spacing
   always @(posedge ref_clk) cyc <= cyc + 1;
   // ----------------
   // n accesses under one strobe, later ones step the column only
   // ----------------
   task automatic xfer(input logic rw, input logic [23:0] a, input int n,
                       output int lat, output int t0, output int t1);
      int c;
      @(posedge ref_clk);
      bus_strobe_n <= 1'b0;
      bus_rw <= rw;
      bus_addr <= a;
      lat = -1;
      t0 = 0;
      t1 = 0;
      for (int i = 0; i < n; i++) begin
         c = -1;
         // waits on ready alone, bounded
         do begin
            @(posedge ref_clk);
            c++;
         end while (bus_ready !== 1'b1 && c < 30);
         lat = (bus_ready === 1'b1) ? c : -1;
         if (i == 0) t0 = cyc;
         t1 = cyc;
         if (lat < 0) break;
         if (i < n - 1) bus_addr <= a + 24'(i + 1); // strobe kept low, same 512-word page
      end
      // released address is scrambled so stale values cannot pass
      bus_strobe_n <= 1'b1;
      bus_addr <= ~bus_addr;
      // let the ras precharge run out before the next strobe
      repeat (2) @(posedge ref_clk);
   endtask : xfer
endmodule : pmdc_cpu_model

// ### test/pmdc_ctrl_sva.sv
// pmdc_ctrl_sva: port checks for the page-mode dram controller
// assumes one ref_clk domain and a synchronous rst_n
`timescale 1ns/1ps
module pmdc_ctrl_sva (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic bus_strobe_n,
   input wire logic bus_rw,
   input wire logic [23:0] bus_addr,
   input wire logic bus_ready,
   input wire logic module_select,
   input wire logic row_column_select,
   input wire logic [8:0] dram_mux_address,
   input wire logic data_latch_en,
   input wire pmdc_pkg::pmdc_dram_ctl_s dram_ctl
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // ----------------
   // checks
   // ----------------
   board_select_a: assert property (module_select == (bus_addr[23:20] == 4'h4))
      else $error("module select wrong");
   strobe_precharge_a: assert property ($rose(bus_strobe_n) |=> &dram_ctl.ras_n && &dram_ctl.cas_n)
      else $error("no precharge after strobe");
   // address is scrambled once strobe is high, so only judge while low
   bank_decode_a: assert property (!bus_strobe_n && !(dram_ctl.ras_n inside {4'hF, 4'h0})
      |-> !dram_ctl.ras_n[bus_addr[19:18]]) else $error("wrong bank strobed");
   ready_latency_a: assert property ($fell(bus_strobe_n) && module_select
      |-> !bus_ready[*3] ##[1:30] bus_ready) else $error("ready timing wrong");
   ready_pulse_a: assert property (bus_ready |=> !bus_ready)
      else $error("ready longer than one cycle");
   cbr_refresh_a: assert property (dram_ctl.ras_n == 4'h0
      |-> dram_ctl.cas_n == 4'h0 && $past(dram_ctl.cas_n) == 4'h0) else $error("refresh not cas first");
   page_hold_a: assert property (!bus_strobe_n && bus_rw && !(dram_ctl.ras_n inside {4'hF, 4'h0})
      |=> $stable(dram_ctl.ras_n)) else $error("row strobe dropped in page");
   mux_order_a: assert property ($past(dram_ctl.ras_n) == 4'hF && !(dram_ctl.ras_n inside {4'hF, 4'h0})
      |-> !row_column_select && dram_mux_address == bus_addr[17:9]
      ##1 row_column_select && dram_mux_address == bus_addr[8:0]) else $error("mux order wrong");
   read_latch_a: assert property (bus_ready && bus_rw |-> data_latch_en)
      else $error("read data not latched");
   write_latch_a: assert property (bus_ready && !bus_rw |-> !data_latch_en)
      else $error("latch opened on write");
   write_enable_a: assert property (!(dram_ctl.ras_n inside {4'hF, 4'h0}) && !(&dram_ctl.cas_n)
      |-> dram_ctl.we_n == bus_rw) else $error("write enable wrong");
endmodule : pmdc_ctrl_sva

bind pmdc_ctrl pmdc_ctrl_sva pmdc_ctrl_sva_inst (.ref_clk, .rst_n, .bus_strobe_n, .bus_rw, .bus_addr,
   .bus_ready, .module_select, .row_column_select, .dram_mux_address, .data_latch_en, .dram_ctl);

// ### test/pmdc_tb.sv
// testbench: self-checking bench for pmdc_ctrl
// assumes pmdc_cpu_model as bus master and the bound checker
`timescale 1ns/1ps
module testbench;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic host_dma_ack_refresh_req = 1'b0;
   logic bus_strobe_n, bus_rw, bus_ready, module_select, row_column_select;
   logic [23:0] bus_addr;
   logic [8:0] dram_mux_address;
   logic data_latch_en;
   pmdc_pkg::pmdc_dram_ctl_s dram_ctl;
   logic [3:0] prev_ras = 4'hF;
   logic [3:0] last_bank = 4'hF;
   int errors = 0;
   int num_checks = 0;
   int refreshes = 0;
   int cycles = 0;
   int lat, t0, t1, t2, cnt;
   pmdc_ctrl pmdc_ctrl_inst (.ref_clk, .rst_n, .bus_strobe_n, .bus_rw, .bus_addr,
      .host_dma_ack_refresh_req, .bus_ready, .module_select, .row_column_select,
      .dram_mux_address, .data_latch_en, .dram_ctl);
   pmdc_cpu_model pmdc_cpu_model_inst (.ref_clk, .bus_ready, .bus_strobe_n, .bus_rw, .bus_addr);
   initial forever #5 ref_clk = ~ref_clk;
   // ----------------
   // monitor: refresh count, last bank, hang limit
   // ----------------
   always @(posedge ref_clk) begin
      prev_ras <= dram_ctl.ras_n;
      if (dram_ctl.ras_n == 4'h0 && prev_ras != 4'h0) refreshes <= refreshes + 1;
      if (!(dram_ctl.ras_n inside {4'hF, 4'h0})) last_bank <= dram_ctl.ras_n;
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         errors = errors + 1;
         conclude();
      end
   end
   task automatic compare_int(input int got, input int exp);
      num_checks++;
      if (got != exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : compare_int
   task automatic compare_vec(input logic [3:0] got, input logic [3:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : compare_vec
   task automatic test_banks();
      for (int b = 0; b < 4; b++) begin
         pmdc_cpu_model_inst.xfer(1'b0, {4'h4, 2'(b), 9'h0A5, 9'h010}, 1, lat, t0, t1);
         compare_int(lat, 3);
         compare_vec(last_bank, ~(4'h1 << b));
         pmdc_cpu_model_inst.xfer(1'b1, {4'h4, 2'(b), 9'h15A, 9'h1F0}, 1, lat, t2, t0);
         compare_int(lat, 3);
         compare_int(int'(t2 - t1 >= 4), 1);
      end
      $display("banks done");
   endtask : test_banks
   task automatic test_page();
      pmdc_cpu_model_inst.xfer(1'b1, 24'h4A3C10, 4, lat, t0, t1);
      compare_int(lat, 2);
      $display("page done");
   endtask : test_page
   task automatic test_range();
      // both sides just outside the board window
      pmdc_cpu_model_inst.xfer(1'b1, 24'h500000, 1, lat, t0, t1);
      compare_int(lat, -1);
      pmdc_cpu_model_inst.xfer(1'b1, 24'h3FFFFF, 1, lat, t0, t1);
      compare_int(lat, -1);
      compare_vec(dram_ctl.ras_n, 4'hF);
      $display("range done");
   endtask : test_range
   task automatic test_refresh();
      cnt = refreshes;
      for (int k = 0; k < 2; k++) begin
         @(posedge ref_clk);
         host_dma_ack_refresh_req <= 1'b1;
         repeat (20) @(posedge ref_clk);
         host_dma_ack_refresh_req <= 1'b0;
         repeat (1180) @(posedge ref_clk);
         compare_int(refreshes - cnt, k + 1);
      end
      $display("refresh done");
   endtask : test_refresh
   task automatic test_held();
      cnt = refreshes;
      @(posedge ref_clk);
      host_dma_ack_refresh_req <= 1'b1;
      pmdc_cpu_model_inst.xfer(1'b1, 24'h4C0200, 8, lat, t0, t1);
      compare_int(refreshes - cnt, 0);
      host_dma_ack_refresh_req <= 1'b0;
      pmdc_cpu_model_inst.xfer(1'b1, 24'h440000, 1, lat, t0, t1);
      compare_int(int'(lat > 3), 1);
      compare_int(refreshes - cnt, 1);
      $display("held done");
   endtask : test_held
   task automatic conclude();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : conclude
   initial begin
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      test_banks();
      test_page();
      test_range();
      test_refresh();
      test_held();
      conclude();
   end
endmodule : testbench
